// ---- shared/ssmr_map.svh ----
/*
  Address map, field positions, reset values and character lengths of the
  synchronous serial port. Assumes a 32-bit AHB-Lite bus, one byte-wide
  register per aligned word, decoded from the low address byte.
*/
`ifndef SSMR_MAP_SVH
`define SSMR_MAP_SVH
// Byte addresses
`define SSMR_A_RXSTAT 8'h00
`define SSMR_A_TXSTAT 8'h04
`define SSMR_A_RXDATA 8'h08
`define SSMR_A_TXHOLD 8'h0c
`define SSMR_A_DIVLO 8'h10
`define SSMR_A_DIVHI 8'h14
`define SSMR_A_BAUD1 8'h18
`define SSMR_A_BAUD2 8'h1c
`define SSMR_A_IRQEN 8'h20
`define SSMR_A_FLAGS 8'h24
// receive_status_control fields
`define SSMR_B_PORTEN 7
`define SSMR_B_RXNINE 6
`define SSMR_B_SINGLE 5
`define SSMR_B_CONT 4
`define SSMR_B_OVR 1
`define SSMR_B_RXNINTH 0
// transmit_status_control fields
`define SSMR_B_CLKSRC 7
`define SSMR_B_TXNINE 6
`define SSMR_B_XMITEN 5
`define SSMR_B_SYNCMODE 4
`define SSMR_B_HISPEED 2
`define SSMR_B_SHIFTIDLE 1
`define SSMR_B_TXNINTH 0
// baud_control fields
`define SSMR_B_RXIDLE 6
`define SSMR_B_WIDEDIV 3
// Interrupt enable and flag fields
`define SSMR_B_IRQRX 0
`define SSMR_B_IRQTX 1
`define SSMR_B_IRQPER 2
`define SSMR_B_IRQGLB 3
`define SSMR_B_RXFLAG 0
`define SSMR_B_TXFLAG 1
// Reset values and character lengths
`define SSMR_RST_BYTE 8'h00
`define SSMR_LEN8 4'h8
`define SSMR_LEN9 4'h9
`endif

// ---- shared/ssmr_pkg.sv ----
/*
  Types of the synchronous serial port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package ssmr_pkg;
  // Activity of the shift logic on the link
  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_RX,
    LINK_TX
  } ssmr_link_t;
endpackage : ssmr_pkg
`default_nettype wire

// ---- verilog/ssmr_core.sv ----
/*
  Synchronous serial port: master and slave reception, slave and master
  transmission over a shared clock pin and data pin, AHB-Lite registers.
  Assumes a zero-wait AHB-Lite master doing single word transfers, pins
  asynchronous to sys_clk, and external pad logic resolving the enables.
*/
`include "ssmr_map.svh"
`default_nettype none
module ssmr_core #(
  parameter int RX_DEPTH = 2
) (
  // System
  input wire logic sys_clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core power state and requests
  input wire logic coreSleep,
  output logic rxIrq,
  output logic txIrq,
  output logic wakeReq,
  // Link clock pin
  input wire logic clockPinIn,
  output logic clockPinOut,
  output logic clockPinOe,
  // Link data pin
  input wire logic dataPinIn,
  output logic dataPinOut,
  output logic dataPinOe
);
  localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(RX_DEPTH);

  // Control and status storage
  logic portEn_reg, rxNine_reg, single_reg, cont_reg, ovr_reg;
  logic clkSrc_reg, txNine_reg, xmitEn_reg, syncMode_reg;
  logic hiSpeed_reg, txNinth_reg, wideDiv_reg;
  logic [7:0] divLo_reg, divHi_reg;
  logic [3:0] irqEn_reg;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  // Link state
  ssmr_pkg::ssmr_link_t state_reg;
  logic [15:0] divCnt_reg;
  logic clkGen_reg;
  logic [2:0] clkSync_reg;
  logic [1:0] dataSync_reg;
  logic [3:0] bitCnt_reg;
  logic [8:0] rxSh_reg;
  logic [8:0] tsr_reg, hold_reg;
  logic tsrFull_reg, holdFull_reg;
  // Receive buffer
  logic [8:0] mem_reg [RX_DEPTH];
  logic [PW-1:0] wrPtr_reg, rdPtr_reg;
  logic [CW-1:0] cnt_reg;

  // Address match, used by read and write decode
  function automatic logic hitA(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : hitA

  // Ring pointer step
  function automatic logic [PW-1:0] stepPtr(input logic [PW-1:0] p);
    return (p == PW'(RX_DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : stepPtr

  // Bus address phase
  logic acc, inMap, rdAcc, popReq;
  assign acc = hsel && htrans[1] && hready;
  assign inMap = (haddr[31:8] == 24'h000000);
  assign rdAcc = acc && !hwrite;
  assign popReq = rdAcc && inMap && hitA(haddr[7:0], `SSMR_A_RXDATA)
    && (cnt_reg != '0);

  // Write data phase strobes
  logic wrRx, wrTx, wrHold, wrLo, wrHi, wrBaud, wrIrq;
  assign wrRx = wrPend_reg && hitA(wrAddr_reg, `SSMR_A_RXSTAT);
  assign wrTx = wrPend_reg && hitA(wrAddr_reg, `SSMR_A_TXSTAT);
  assign wrHold = wrPend_reg && hitA(wrAddr_reg, `SSMR_A_TXHOLD);
  assign wrLo = wrPend_reg && hitA(wrAddr_reg, `SSMR_A_DIVLO);
  assign wrHi = wrPend_reg && hitA(wrAddr_reg, `SSMR_A_DIVHI);
  assign wrBaud = wrPend_reg && (hitA(wrAddr_reg, `SSMR_A_BAUD1)
    || hitA(wrAddr_reg, `SSMR_A_BAUD2));
  assign wrIrq = wrPend_reg && hitA(wrAddr_reg, `SSMR_A_IRQEN);

  // Mode selection
  logic unitOn, master, slave, rxMode, linkBusy;
  assign unitOn = portEn_reg && syncMode_reg;
  assign master = unitOn && clkSrc_reg;
  assign slave = unitOn && !clkSrc_reg;
  // Slave listens to the continuous enable only
  assign rxMode = master ? (single_reg || cont_reg) : cont_reg;
  assign linkBusy = (state_reg != ssmr_pkg::LINK_IDLE);

  // Flags
  logic rxFlag, txFlag;
  assign rxFlag = (cnt_reg != '0);
  assign txFlag = !holdFull_reg;

  // Master bit clock from the divisor; in reception a divisor below 3
  // outruns the pin register plus synchroniser lag, so bits arrive late
  logic [15:0] divisor;
  logic tick, genLead, genTrail, slvLead, slvTrail, lead, trail;
  assign divisor = wideDiv_reg ? {divHi_reg, divLo_reg} : {8'h00, divLo_reg};
  assign tick = (divCnt_reg == 16'h0000);
  assign genLead = master && linkBusy && tick && !clkGen_reg;
  assign genTrail = master && linkBusy && tick && clkGen_reg;
  // Edges seen on the partner's clock after synchronising
  assign slvLead = slave && clkSync_reg[1] && !clkSync_reg[2];
  assign slvTrail = slave && !clkSync_reg[1] && clkSync_reg[2];
  assign lead = genLead || slvLead;
  assign trail = genTrail || slvTrail;

  // Character framing
  logic [3:0] charLen;
  logic lastBit, rxDone, txDone, push, ovrSet;
  logic [8:0] rxNext, rxWord;
  always_comb begin
    if (state_reg == ssmr_pkg::LINK_RX) begin
      charLen = rxNine_reg ? `SSMR_LEN9 : `SSMR_LEN8;
    end else begin
      charLen = txNine_reg ? `SSMR_LEN9 : `SSMR_LEN8;
    end
  end
  assign lastBit = (bitCnt_reg == charLen - 4'h1);
  assign rxDone = (state_reg == ssmr_pkg::LINK_RX) && trail && lastBit;
  assign txDone = (state_reg == ssmr_pkg::LINK_TX) && trail && lastBit;
  assign rxNext = {dataSync_reg[1], rxSh_reg[8:1]};
  // Eight-bit characters end one place higher in the shifter
  assign rxWord = rxNine_reg ? rxNext : {1'b0, rxNext[8:1]};
  assign push = rxDone && ((cnt_reg != FULL) || popReq);
  assign ovrSet = rxDone && (cnt_reg == FULL) && !popReq;

  // Bus response; zero wait, always OKAY
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Write address capture; word writes only
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else begin
      wrPend_reg <= acc && hwrite && inMap && (hsize == 3'h2);
      wrAddr_reg <= haddr[7:0];
    end
  end

  // Read data, taken at the address phase so it stands in the data phase
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (rdAcc && inMap) begin
      hrdata <= 32'h00000000;
      case (haddr[7:0])
        `SSMR_A_RXSTAT: hrdata[7:0] <= {portEn_reg, rxNine_reg, single_reg,
          cont_reg, 2'h0, ovr_reg, rxFlag && mem_reg[rdPtr_reg][8]};
        `SSMR_A_TXSTAT: hrdata[7:0] <= {clkSrc_reg, txNine_reg, xmitEn_reg,
          syncMode_reg, 1'b0, hiSpeed_reg, !tsrFull_reg, txNinth_reg};
        // Empty buffer reads zero, never a stale or unwritten entry
        `SSMR_A_RXDATA: hrdata[7:0] <= rxFlag ? mem_reg[rdPtr_reg][7:0] : 8'h00;
        `SSMR_A_DIVLO: hrdata[7:0] <= divLo_reg;
        `SSMR_A_DIVHI: hrdata[7:0] <= divHi_reg;
        `SSMR_A_BAUD1, `SSMR_A_BAUD2: hrdata[7:0] <= {1'b0, !linkBusy,
          2'h0, wideDiv_reg, 3'h0};
        `SSMR_A_IRQEN: hrdata[3:0] <= irqEn_reg;
        `SSMR_A_FLAGS: hrdata[1:0] <= {txFlag, rxFlag};
        default: hrdata <= 32'h00000000;
      endcase
    end else begin
      hrdata <= 32'h00000000;
    end
  end

  // Receive control; hardware drops single enable after one master-mode character
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {portEn_reg, rxNine_reg, single_reg, cont_reg} <= 4'h0;
    end else if (wrRx) begin
      portEn_reg <= hwdata[`SSMR_B_PORTEN];
      rxNine_reg <= hwdata[`SSMR_B_RXNINE];
      single_reg <= hwdata[`SSMR_B_SINGLE];
      cont_reg <= hwdata[`SSMR_B_CONT];
    end else if (rxDone && master) begin
      single_reg <= 1'b0;
    end
  end

  // Overrun: set wins over every clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ovr_reg <= 1'b0;
    end else if (ovrSet) begin
      ovr_reg <= 1'b1;
    end else if (!portEn_reg || (!cont_reg && (!single_reg || popReq))) begin
      ovr_reg <= 1'b0;
    end
  end

  // Transmit control, divisor, baud and interrupt enables
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {clkSrc_reg, txNine_reg, xmitEn_reg, syncMode_reg} <= 4'h0;
      {hiSpeed_reg, txNinth_reg, wideDiv_reg} <= 3'h0;
      divLo_reg <= `SSMR_RST_BYTE;
      divHi_reg <= `SSMR_RST_BYTE;
      irqEn_reg <= 4'h0;
    end else begin
      if (wrTx) begin
        clkSrc_reg <= hwdata[`SSMR_B_CLKSRC];
        txNine_reg <= hwdata[`SSMR_B_TXNINE];
        xmitEn_reg <= hwdata[`SSMR_B_XMITEN];
        syncMode_reg <= hwdata[`SSMR_B_SYNCMODE];
        hiSpeed_reg <= hwdata[`SSMR_B_HISPEED];
        txNinth_reg <= hwdata[`SSMR_B_TXNINTH];
      end
      if (wrLo) begin
        divLo_reg <= hwdata[7:0];
      end
      if (wrHi) begin
        divHi_reg <= hwdata[7:0];
      end
      if (wrBaud) begin
        wideDiv_reg <= hwdata[`SSMR_B_WIDEDIV];
      end
      if (wrIrq) begin
        irqEn_reg <= hwdata[3:0];
      end
    end
  end

  // Pin synchronisers; only stages 1 and 2 feed logic
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      clkSync_reg <= 3'h0;
      dataSync_reg <= 2'h0;
    end else begin
      clkSync_reg <= {clkSync_reg[1:0], clockPinIn};
      dataSync_reg <= {dataSync_reg[0], dataPinIn};
    end
  end

  // Master clock generator; stops low the moment the link goes idle
  always_ff @(posedge sys_clk) begin
    if (!rstn || !master || !linkBusy) begin
      divCnt_reg <= 16'h0000;
      clkGen_reg <= 1'b0;
    end else if (tick) begin
      divCnt_reg <= divisor;
      clkGen_reg <= !clkGen_reg;
    end else begin
      divCnt_reg <= divCnt_reg - 16'h0001;
    end
  end

  // Link sequencer
  always_ff @(posedge sys_clk) begin
    if (!rstn || !unitOn) begin
      state_reg <= ssmr_pkg::LINK_IDLE;
    end else begin
      case (state_reg)
        ssmr_pkg::LINK_IDLE: begin
          if (rxMode && !ovr_reg) begin
            state_reg <= ssmr_pkg::LINK_RX;
          end else if (!rxMode && xmitEn_reg && tsrFull_reg) begin
            state_reg <= ssmr_pkg::LINK_TX;
          end
        end
        ssmr_pkg::LINK_RX: begin
          // Dropping the enable discards a partial character
          if (!rxMode || ovrSet) begin
            state_reg <= ssmr_pkg::LINK_IDLE;
          end else if (rxDone && master && !cont_reg) begin
            state_reg <= ssmr_pkg::LINK_IDLE;
          end
        end
        ssmr_pkg::LINK_TX: begin
          if (txDone || rxMode || !xmitEn_reg) begin
            state_reg <= ssmr_pkg::LINK_IDLE;
          end
        end
        default: state_reg <= ssmr_pkg::LINK_IDLE;
      endcase
    end
  end

  // Bit counter, one bit per clock cycle counted on the trailing edge
  always_ff @(posedge sys_clk) begin
    if (!rstn || !linkBusy) begin
      bitCnt_reg <= 4'h0;
    end else if (trail) begin
      bitCnt_reg <= lastBit ? 4'h0 : bitCnt_reg + 4'h1;
    end
  end

  // Receive shifter, LSB first, sampled on the trailing edge
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rxSh_reg <= 9'h000;
    end else if (state_reg == ssmr_pkg::LINK_RX && trail) begin
      rxSh_reg <= rxNext;
    end
  end

  // Holding register and shift register, loaded as soon as shifter frees
  always_ff @(posedge sys_clk) begin
    if (!rstn || !portEn_reg) begin
      holdFull_reg <= 1'b0;
      tsrFull_reg <= 1'b0;
      hold_reg <= 9'h000;
      tsr_reg <= 9'h000;
    end else begin
      if (txDone) begin
        tsrFull_reg <= 1'b0;
      end else if (!tsrFull_reg && holdFull_reg) begin
        tsr_reg <= hold_reg;
        tsrFull_reg <= 1'b1;
      end else if (state_reg == ssmr_pkg::LINK_TX && lead) begin
        tsr_reg <= {1'b0, tsr_reg[8:1]};
      end
      if (wrHold) begin
        hold_reg <= {txNinth_reg, hwdata[7:0]};
        holdFull_reg <= 1'b1;
      end else if (!tsrFull_reg && holdFull_reg) begin
        holdFull_reg <= 1'b0;
      end
    end
  end

  // Data pin: bit changes on the leading edge only
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dataPinOut <= 1'b0;
    end else if (state_reg == ssmr_pkg::LINK_TX && lead) begin
      dataPinOut <= tsr_reg[0];
    end
  end

  // Pin drivers: clock in master only, data whenever the unit is on, transmit is enabled and reception is off
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      clockPinOut <= 1'b0;
      clockPinOe <= 1'b0;
      dataPinOe <= 1'b0;
    end else begin
      clockPinOut <= clkGen_reg;
      clockPinOe <= master;
      dataPinOe <= unitOn && !rxMode && xmitEn_reg;
    end
  end

  // Receive buffer, flushed when the port is switched off
  always_ff @(posedge sys_clk) begin
    if (!rstn || !portEn_reg) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        mem_reg[wrPtr_reg] <= rxWord;
        wrPtr_reg <= stepPtr(wrPtr_reg);
      end
      if (popReq) begin
        rdPtr_reg <= stepPtr(rdPtr_reg);
      end
      cnt_reg <= cnt_reg + CW'(push) - CW'(popReq);
    end
  end

  // Interrupt requests and wake-up; wake works without the global enable
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rxIrq <= 1'b0;
      txIrq <= 1'b0;
      wakeReq <= 1'b0;
    end else begin
      rxIrq <= rxFlag && irqEn_reg[`SSMR_B_IRQRX]
        && irqEn_reg[`SSMR_B_IRQPER] && irqEn_reg[`SSMR_B_IRQGLB];
      txIrq <= txFlag && irqEn_reg[`SSMR_B_IRQTX]
        && irqEn_reg[`SSMR_B_IRQPER] && irqEn_reg[`SSMR_B_IRQGLB];
      wakeReq <= coreSleep && ((rxFlag && irqEn_reg[`SSMR_B_IRQRX])
        || (txFlag && irqEn_reg[`SSMR_B_IRQTX]
        && irqEn_reg[`SSMR_B_IRQPER]));
    end
  end

  // Checks
  a_overrun_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!cont_reg && !single_reg && !ovrSet) |=> !ovr_reg)
    else $error("overrun not cleared");
  a_port_flush: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!portEn_reg && !ovrSet) |=> (cnt_reg == '0) && !ovr_reg && !holdFull_reg)
    else $error("port off did not flush");
  a_overrun_blocks: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ovrSet && portEn_reg) |=> ovr_reg && (cnt_reg == FULL)
      && (state_reg == ssmr_pkg::LINK_IDLE))
    else $error("overrun did not block");
  a_single_drop: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rxDone && master && !wrRx) |=> !single_reg)
    else $error("single enable not dropped");
  a_rd_pop: assert property (@(posedge sys_clk) disable iff (!rstn)
    (popReq && !push && portEn_reg) |=> cnt_reg == $past(cnt_reg) - CW'(1))
    else $error("read did not pop");
  a_rx_irq: assert property (@(posedge sys_clk) disable iff (!rstn)
    rxIrq |-> $past(rxFlag && irqEn_reg[`SSMR_B_IRQRX]))
    else $error("receive irq without cause");
  a_slave_rx: assert property (@(posedge sys_clk) disable iff (!rstn)
    (slave && single_reg && !cont_reg) |-> state_reg != ssmr_pkg::LINK_RX)
    else $error("slave took single enable");
  a_data_lead: assert property (@(posedge sys_clk) disable iff (!rstn)
    $changed(dataPinOut) |-> $past(lead))
    else $error("data changed off leading edge");
  a_tx_wake: assert property (@(posedge sys_clk) disable iff (!rstn)
    (coreSleep && txFlag && irqEn_reg[`SSMR_B_IRQTX]
      && irqEn_reg[`SSMR_B_IRQPER]) |=> wakeReq)
    else $error("transmit flag did not wake");
  a_slave_no_clock: assert property (@(posedge sys_clk) disable iff (!rstn)
    slave |=> !clockPinOe)
    else $error("slave drove clock");
endmodule : ssmr_core
`default_nettype wire

// ---- tb/ssmr_link_partner.sv ----
/*
  Behavioural far-side device of the serial link: link master toward a
  slave core, data source toward a master core.
  Assumes the bench resolves both pins from the output enables.
*/
`default_nettype none
module ssmr_link_partner (
  // Resolved pins
  input wire logic clkLine,
  input wire logic datLine,
  input wire logic dutClkOe,
  // Drives used when the core lets go
  output logic clkDrv,
  output logic datDrv
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] mstrData;
  initial begin
    clkDrv = 1'b0;
    datDrv = 1'b1;
    mstrData = 9'h000;
  end
  // Core is master: next bit on its leading edge
  always @(posedge clkLine) begin
    if (dutClkOe) begin
      datDrv <= mstrData[0];
      mstrData <= mstrData >> 1;
    end
  end
  // Slave frame, LSB first; clock stands low outside frames
  task automatic frame(input logic [8:0] d, input int n, output logic [8:0] q);
    q = 9'h000;
    for (int i = 0; i < n; i++) begin
      clkDrv = 1'b1;
      datDrv = d[i];
      #62.5;
      clkDrv = 1'b0;
      q[i] = datLine;
      #62.5;
    end
    datDrv = ~datDrv; // Released line must not keep the last bit
  endtask : frame
endmodule : ssmr_link_partner
`default_nettype wire

// ---- tb/ssmr_core_tb.sv ----
/*
  Self-checking bench of the synchronous serial port: slave receive with
  overrun, slave transmit in sleep, master single receive.
  Assumes the zero-wait bus and the link timing of the core.
*/
`include "ssmr_map.svh"
`default_nettype none
module ssmr_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rstn, hsel, hwrite, hready, hreadyout, hresp, coreSleep;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic rxIrq, txIrq, wakeReq, clockPinOut, clockPinOe, dataPinOut, dataPinOe;
  logic pClk, pDat;
  logic [8:0] d [3];
  logic [8:0] got;
  int err_count, n_checks, seed;
  assign hready = hreadyout;
  // Wire level from whoever drives it
  wire logic clkLine = clockPinOe ? clockPinOut : pClk;
  wire logic datLine = dataPinOe ? dataPinOut : pDat;
  ssmr_core uut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .coreSleep(coreSleep), .rxIrq(rxIrq), .txIrq(txIrq), .wakeReq(wakeReq),
    .clockPinIn(clkLine), .clockPinOut(clockPinOut), .clockPinOe(clockPinOe),
    .dataPinIn(datLine), .dataPinOut(dataPinOut), .dataPinOe(dataPinOe));
  ssmr_link_partner uP (.clkLine(clkLine), .datLine(datLine),
    .dutClkOe(clockPinOe), .clkDrv(pClk), .datDrv(pDat));
  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One single transfer; address phase held until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // Frames take about 1.1 us; whole run is near 7.5 us
  initial begin
    #100us;
    err_count++;
    print_verdict();
  end
  initial begin
    seed = 32'h4221;
    {rstn, hsel, hwrite, coreSleep} = 4'h0;
    htrans = 2'b00;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    hsize = 3'b010;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    // Reset values, unmapped place
    bus(1'b0, `SSMR_A_RXSTAT, 32'h0);
    chk("rxstat", 32'h0, q);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("hresp", 32'h0, {31'h0, hresp});
    // Slave receive, single enable set but ignored, core asleep
    bus(1'b1, `SSMR_A_TXSTAT, 32'h10);
    bus(1'b1, `SSMR_A_RXSTAT, 32'hf0);
    bus(1'b1, `SSMR_A_IRQEN, 32'h0d);
    coreSleep <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      d[i] = 9'($random(seed));
      uP.frame(d[i], 9, got);
      repeat (4) @(posedge sys_clk);
      if (i == 0) chk("wake", 32'h1, {31'h0, wakeReq});
      if (i == 0) chk("rxirq", 32'h1, {31'h0, rxIrq});
    end
    chk("rx oe", 32'h0, {31'h0, dataPinOe});
    coreSleep <= 1'b0;
    bus(1'b0, `SSMR_A_RXSTAT, 32'h0);
    chk("overrun", 32'h1, {31'h0, q[`SSMR_B_OVR]});
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, `SSMR_A_RXSTAT, 32'h0);
      chk("ninth", {31'h0, d[i][8]}, {31'h0, q[0]});
      bus(1'b0, `SSMR_A_RXDATA, 32'h0);
      chk("rxdata", {24'h0, d[i][7:0]}, q);
    end
    bus(1'b0, `SSMR_A_FLAGS, 32'h0);
    chk("rx empty", 32'h0, {31'h0, q[`SSMR_B_RXFLAG]});
    bus(1'b1, `SSMR_A_RXSTAT, 32'hc0);
    bus(1'b0, `SSMR_A_RXSTAT, 32'h0);
    chk("ovr clear", 32'h0, {31'h0, q[`SSMR_B_OVR]});
    // Slave transmit of two bytes while asleep
    bus(1'b1, `SSMR_A_RXSTAT, 32'h80);
    bus(1'b1, `SSMR_A_TXSTAT, 32'h30);
    bus(1'b1, `SSMR_A_IRQEN, 32'h06);
    coreSleep <= 1'b1;
    d[0] = 9'($random(seed));
    d[1] = 9'($random(seed));
    bus(1'b1, `SSMR_A_TXHOLD, {24'h0, d[0][7:0]});
    bus(1'b1, `SSMR_A_TXHOLD, {24'h0, d[1][7:0]});
    bus(1'b0, `SSMR_A_FLAGS, 32'h0);
    chk("tx flag", 32'h0, {31'h0, q[`SSMR_B_TXFLAG]});
    chk("no wake", 32'h0, {31'h0, wakeReq});
    chk("tx oe", 32'h1, {31'h0, dataPinOe});
    for (int i = 0; i < 2; i++) begin
      uP.frame(9'h0, 8, got);
      chk("tx byte", {24'h0, d[i][7:0]}, {23'h0, got});
      repeat (6) @(posedge sys_clk);
      if (i == 0) chk("wake tx", 32'h1, {31'h0, wakeReq});
      // Global enable is off, so the flag wakes but raises no transmit interrupt request
      if (i == 0) chk("txirq", 32'h0, {31'h0, txIrq});
    end
    coreSleep <= 1'b0;
    // Master single receive with a random small divisor
    bus(1'b1, `SSMR_A_TXSTAT, 32'h90);
    // Divisor of 3 or more leaves room for the core's sampling lag
    d[2] = 9'(3 + {$random(seed)} % 4);
    bus(1'b1, `SSMR_A_DIVLO, {23'h0, d[2]});
    bus(1'b0, `SSMR_A_DIVLO, 32'h0);
    chk("div lo", {23'h0, d[2]}, q);
    chk("clk oe", 32'h1, {31'h0, clockPinOe});
    uP.mstrData = 9'($random(seed));
    d[1] = uP.mstrData;
    bus(1'b1, `SSMR_A_RXSTAT, 32'ha0);
    for (int i = 0; i < 200 && q[0] !== 1'b1; i++) bus(1'b0, `SSMR_A_FLAGS, 32'h0);
    bus(1'b0, `SSMR_A_RXDATA, 32'h0);
    chk("master rx", {24'h0, d[1][7:0]}, q);
    bus(1'b0, `SSMR_A_RXSTAT, 32'h0);
    chk("single off", 32'h0, {31'h0, q[`SSMR_B_SINGLE]});
    chk("clk idle", 32'h0, {31'h0, clockPinOut});
    print_verdict();
  end
endmodule : ssmr_core_tb
`default_nettype wire
